// *** inc/adcr_pkg.sv ***
// Constants for the converter channel control registers.
// Assumes a 32-bit word bus where byte address equals register index times four.
`default_nettype none
package adcr_pkg;
	localparam int DATA_W = 16;
	localparam int CODE_W = 10;
	localparam int N_IN = 8;
	localparam int N_OUT = 4;
	localparam logic [5:0] IDX_DAC_DATA0 = 6'h20;
	localparam logic [5:0] IDX_CTRL = 6'h28;
	localparam logic [5:0] IDX_STATUS = 6'h29;
	localparam logic [5:0] IDX_CLR_VAL0 = 6'h2F;
	localparam logic [5:0] IDX_SEL = 6'h37;
	localparam logic [5:0] IDX_RANGE = 6'h38;
	localparam logic [5:0] IDX_FORCE = 6'h39;
	localparam logic [5:0] IDX_SYNC = 6'h3A;
	localparam logic [15:0] RST_SEL = 16'h0000;
	localparam logic [15:0] RST_RANGE = 16'hFF00;
	localparam logic [15:0] RST_FORCE = 16'h0000;
	localparam logic [15:0] RST_SYNC = 16'h0000;
	localparam logic [9:0] RST_CODE = 10'h000;
	localparam logic [15:0] WM_SEL = 16'h7FE0;
	localparam logic [15:0] WM_RANGE = 16'hFF00;
	localparam logic [15:0] WM_FORCE = 16'h000F;
	localparam logic [15:0] WM_SYNC = 16'h000F;
	localparam logic [15:0] WM_CODE = 16'h03FF;
	localparam int SEL_POS [N_IN] = '{14, 13, 11, 10, 8, 7, 6, 5};
	localparam int RANGE_MSB = 15;
	localparam int CTRL_LOAD = 0;
	localparam int CTRL_CONV = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_CH_LSB = 1;
	localparam int ST_PEND_LSB = 4;
endpackage
`default_nettype wire

// *** inc/adcr_reg_if.sv ***
// Carrier between the bus slave and the register file.
// Assumes both ends run on sys_clk; commit is a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
interface adcr_reg_if;
	logic commit;
	logic [5:0] idx;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic [15:0] rdata;
	modport slave (output commit, idx, wdata, wmask, input rdata);
	modport regs (input commit, idx, wdata, wmask, output rdata);
endinterface
`default_nettype wire

// *** rtl/adcr_bus_slave.sv ***
// Avalon-MM slave front end with one wait state per access.
// Assumes a master that holds its request until waitrequest is seen low.
`timescale 1ns/100ps
`default_nettype none
module adcr_bus_slave (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	adcr_reg_if.slave regs
);
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} adcr_slv_type;
	adcr_slv_type st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
		if (avs_read & ~st_r.ack) begin
			st_nxt.rdata = regs.rdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_waitrequest = ~st_r.ack;
	assign avs_readdata = {16'h0000, st_r.rdata};
	assign regs.idx = avs_address[7:2];
	assign regs.wdata = avs_writedata[15:0];
	assign regs.wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign regs.commit = st_r.ack & avs_write;
endmodule
`default_nettype wire

// *** rtl/adcr_dac_chan.sv ***
// One output channel: data holding, sync or async update, forced clear value.
// Assumes data_wr and load are one-cycle strobes on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module adcr_dac_chan #(
	parameter int CODE_W = 10
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic data_wr,
	input wire logic [CODE_W-1:0] wdata,
	input wire logic [CODE_W-1:0] clear_value,
	input wire logic force_clear,
	input wire logic synchronous,
	input wire logic load,
	output logic [CODE_W-1:0] data,
	output logic [CODE_W-1:0] live,
	output logic [CODE_W-1:0] code,
	output logic pending
);
	typedef struct packed {
		logic [CODE_W-1:0] data;
		logic [CODE_W-1:0] live;
		logic [CODE_W-1:0] code;
		logic pending;
	} adcr_chan_type;
	adcr_chan_type st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (load & synchronous & st_r.pending) begin
			st_nxt.live = st_r.data;
			st_nxt.pending = 1'b0;
		end
		if (data_wr) begin
			st_nxt.data = wdata;
			if (synchronous) begin
				st_nxt.pending = 1'b1;
			end else begin
				st_nxt.live = wdata;
				st_nxt.pending = 1'b0;
			end
		end
		st_nxt.code = force_clear ? clear_value : st_nxt.live;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign data = st_r.data;
	assign live = st_r.live;
	assign code = st_r.code;
	assign pending = st_r.pending;
endmodule
`default_nettype wire

// *** rtl/adcr_top.sv ***
// Register file for input selection, input range, output clear forcing and update mode.
// Assumes an Avalon-MM master on sys_clk and a converter engine that consumes scan strobes.
`timescale 1ns/100ps
`default_nettype none
module adcr_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [7:0] input_select,
	output logic [7:0] input_range_double,
	output logic [3:0] output_force_clear,
	output logic [3:0] output_synchronous,
	output logic [3:0][9:0] dac_code,
	output logic conv_strobe,
	output logic [2:0] conv_channel,
	output logic conv_range_double
);
	typedef enum logic {
		S_IDLE,
		S_SCAN
	} adcr_scan_type;

	typedef struct packed {
		logic [15:0] sel;
		logic [15:0] range;
		logic [15:0] force_clr;
		logic [15:0] sync;
		logic [3:0][9:0] clrv;
		adcr_scan_type scan;
		logic [2:0] ch;
		logic load;
		logic strobe;
		logic [2:0] strobe_ch;
		logic strobe_rng;
	} adcr_top_type;

	adcr_top_type st_r, st_nxt;
	adcr_reg_if bus ();

	logic [3:0][9:0] dac_data;
	logic [3:0][9:0] dac_live;
	logic [3:0] dac_pending;
	logic [3:0] dac_wr;
	logic [9:0] wcode;
	logic start;
	logic cur_sel;
	logic cur_rng;

	////////////////////////////////////////////////////////////////////////////////
	// Bus front end.

	adcr_bus_slave u_slave (
		.sys_clk(sys_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.regs(bus.slave)
	);

	// Merges the enabled byte lanes of a write into the writable bits only.
	function automatic logic [15:0] adcr_merge(
		input logic [15:0] old,
		input logic [15:0] wd,
		input logic [15:0] wm,
		input logic [15:0] regm
	);
		logic [15:0] m;
		m = wm & regm;
		return (old & ~m) | (wd & m);
	endfunction

	assign wcode = bus.wdata[9:0];
	assign start = bus.commit & (bus.idx == adcr_pkg::IDX_CTRL)
		& bus.wdata[adcr_pkg::CTRL_CONV] & bus.wmask[adcr_pkg::CTRL_CONV];

	property p_wait_one;
		@(posedge sys_clk) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus request not answered after one wait state");

	property p_sel_read;
		@(posedge sys_clk) disable iff (rst)
		avs_read && avs_waitrequest && bus.idx == adcr_pkg::IDX_SEL
			|=> avs_readdata == {16'h0000, $past(st_r.sel)};
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("select register read back wrong");

	property p_force_read;
		@(posedge sys_clk) disable iff (rst)
		avs_read && avs_waitrequest && bus.idx == adcr_pkg::IDX_FORCE
			|=> avs_readdata == {28'h0000000, $past(output_force_clear)};
	endproperty
	a_force_read: assert property (p_force_read) else $error("clear register read back wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and the scan sequencer.

	always_comb begin
		logic [15:0] tmp;
		tmp = 16'h0000;
		st_nxt = st_r;
		st_nxt.load = 1'b0;
		st_nxt.strobe = 1'b0;
		if (bus.commit) begin
			case (bus.idx)
				adcr_pkg::IDX_SEL: begin
					st_nxt.sel = adcr_merge(st_r.sel, bus.wdata, bus.wmask, adcr_pkg::WM_SEL);
				end
				adcr_pkg::IDX_RANGE: begin
					st_nxt.range = adcr_merge(st_r.range, bus.wdata, bus.wmask, adcr_pkg::WM_RANGE);
				end
				adcr_pkg::IDX_FORCE: begin
					st_nxt.force_clr = adcr_merge(st_r.force_clr, bus.wdata, bus.wmask, adcr_pkg::WM_FORCE);
				end
				adcr_pkg::IDX_SYNC: begin
					st_nxt.sync = adcr_merge(st_r.sync, bus.wdata, bus.wmask, adcr_pkg::WM_SYNC);
				end
				adcr_pkg::IDX_CTRL: begin
					st_nxt.load = bus.wdata[adcr_pkg::CTRL_LOAD] & bus.wmask[adcr_pkg::CTRL_LOAD];
				end
				default: begin
				end
			endcase
			for (int i = 0; i < adcr_pkg::N_OUT; i++) begin
				if (bus.idx == adcr_pkg::IDX_CLR_VAL0 + 6'(i)) begin
					tmp = adcr_merge({6'h00, st_r.clrv[i]}, bus.wdata, bus.wmask, adcr_pkg::WM_CODE);
					st_nxt.clrv[i] = tmp[9:0];
				end
			end
		end
		case (st_r.scan)
			S_IDLE: begin
				if (start) begin
					st_nxt.scan = S_SCAN;
					st_nxt.ch = 3'h0;
				end
			end
			S_SCAN: begin
				st_nxt.strobe = cur_sel;
				st_nxt.strobe_ch = st_r.ch;
				st_nxt.strobe_rng = cur_rng;
				st_nxt.ch = st_r.ch + 3'h1;
				if (st_r.ch == 3'h7) begin
					st_nxt.scan = S_IDLE;
				end
			end
			default: begin
				st_nxt.scan = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.sel <= adcr_pkg::RST_SEL;
			st_r.range <= adcr_pkg::RST_RANGE;
			st_r.force_clr <= adcr_pkg::RST_FORCE;
			st_r.sync <= adcr_pkg::RST_SYNC;
			st_r.clrv <= {4{adcr_pkg::RST_CODE}};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped indices read as zero.

	always_comb begin
		bus.rdata = 16'h0000;
		case (bus.idx)
			adcr_pkg::IDX_SEL: bus.rdata = st_r.sel;
			adcr_pkg::IDX_RANGE: bus.rdata = st_r.range;
			adcr_pkg::IDX_FORCE: bus.rdata = st_r.force_clr;
			adcr_pkg::IDX_SYNC: bus.rdata = st_r.sync;
			adcr_pkg::IDX_STATUS: begin
				bus.rdata[adcr_pkg::ST_BUSY] = (st_r.scan == S_SCAN);
				bus.rdata[adcr_pkg::ST_CH_LSB +: 3] = st_r.ch;
				bus.rdata[adcr_pkg::ST_PEND_LSB +: 4] = dac_pending;
			end
			default: begin
			end
		endcase
		for (int i = 0; i < adcr_pkg::N_OUT; i++) begin
			if (bus.idx == adcr_pkg::IDX_DAC_DATA0 + 6'(i)) begin
				bus.rdata = {6'h00, dac_data[i]};
			end
			if (bus.idx == adcr_pkg::IDX_CLR_VAL0 + 6'(i)) begin
				bus.rdata = {6'h00, st_r.clrv[i]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input fields and scan outputs.

	for (genvar i = 0; i < adcr_pkg::N_IN; i++) begin : g_in
		assign input_select[i] = st_r.sel[adcr_pkg::SEL_POS[i]];
		assign input_range_double[i] = st_r.range[adcr_pkg::RANGE_MSB - i];
	end

	assign cur_sel = input_select[st_r.ch];
	assign cur_rng = input_range_double[st_r.ch];
	assign conv_strobe = st_r.strobe;
	assign conv_channel = st_r.strobe_ch;
	assign conv_range_double = st_r.strobe_rng;
	assign output_force_clear = st_r.force_clr[3:0];
	assign output_synchronous = st_r.sync[3:0];

	property p_scan_pick;
		@(posedge sys_clk) disable iff (rst)
		st_r.scan == S_SCAN |=> conv_strobe == $past(cur_sel) && conv_channel == $past(st_r.ch);
	endproperty
	a_scan_pick: assert property (p_scan_pick) else $error("scan strobe does not follow select bit");

	property p_scan_len;
		@(posedge sys_clk) disable iff (rst)
		$rose(st_r.scan == S_SCAN) |-> (st_r.scan == S_SCAN)[*8] ##1 (st_r.scan == S_IDLE);
	endproperty
	a_scan_len: assert property (p_scan_len) else $error("scan does not cover eight inputs");

	property p_sel_reset;
		@(posedge sys_clk) rst |=> st_r.sel == 16'h0000 && input_select == 8'h00;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("select register reset value wrong");

	property p_range_scan;
		@(posedge sys_clk) disable iff (rst)
		conv_strobe |-> conv_range_double == $past(cur_rng);
	endproperty
	a_range_scan: assert property (p_range_scan) else $error("range flag does not follow range bit");

	property p_range_reset;
		@(posedge sys_clk) rst |=> input_range_double == 8'hFF && st_r.range == 16'hFF00;
	endproperty
	a_range_reset: assert property (p_range_reset) else $error("range register reset value wrong");

	property p_force_reset;
		@(posedge sys_clk) rst |=> output_force_clear == 4'h0 && st_r.force_clr == 16'h0000;
	endproperty
	a_force_reset: assert property (p_force_reset) else $error("clear register reset value wrong");

	property p_sync_reset;
		@(posedge sys_clk) rst |=> output_synchronous == 4'h0 && st_r.sync == 16'h0000;
	endproperty
	a_sync_reset: assert property (p_sync_reset) else $error("update mode reset value wrong");

	property p_reserved;
		@(posedge sys_clk) disable iff (rst)
		bus.commit && bus.idx == adcr_pkg::IDX_RANGE |=> st_r.range[7:0] == 8'h00 && st_r.sync[15:4] == 12'h000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits took a written value");

	property p_sel_reserved;
		@(posedge sys_clk) disable iff (rst)
		bus.commit && bus.idx == adcr_pkg::IDX_SEL |=> st_r.sel[15] == 1'b0 && st_r.sel[4:0] == 5'h00;
	endproperty
	a_sel_reserved: assert property (p_sel_reserved) else $error("reserved select bits took a value");

	property p_strobe_in_scan;
		@(posedge sys_clk) disable iff (rst)
		st_r.scan != S_SCAN |=> !conv_strobe;
	endproperty
	a_strobe_in_scan: assert property (p_strobe_in_scan) else $error("scan strobe outside a scan");

	property p_load_pulse;
		@(posedge sys_clk) disable iff (rst)
		st_r.load |=> !st_r.load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load trigger longer than one cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Output channels.

	for (genvar i = 0; i < adcr_pkg::N_OUT; i++) begin : g_out
		assign dac_wr[i] = bus.commit & (bus.idx == adcr_pkg::IDX_DAC_DATA0 + 6'(i));

		adcr_dac_chan #(
			.CODE_W(adcr_pkg::CODE_W)
		) u_chan (
			.sys_clk(sys_clk),
			.rst(rst),
			.data_wr(dac_wr[i]),
			.wdata(wcode),
			.clear_value(st_r.clrv[i]),
			.force_clear(output_force_clear[i]),
			.synchronous(output_synchronous[i]),
			.load(st_r.load),
			.data(dac_data[i]),
			.live(dac_live[i]),
			.code(dac_code[i]),
			.pending(dac_pending[i])
		);

		property p_forced;
			@(posedge sys_clk) disable iff (rst)
			output_force_clear[i] |=> dac_code[i] == $past(st_r.clrv[i]);
		endproperty
		a_forced: assert property (p_forced) else $error("forced output not at clear value");

		property p_normal;
			@(posedge sys_clk) disable iff (rst)
			!output_force_clear[i] && !dac_wr[i] && !st_r.load |=> dac_code[i] == $past(dac_live[i]);
		endproperty
		a_normal: assert property (p_normal) else $error("unforced output not at data value");

		property p_async;
			@(posedge sys_clk) disable iff (rst)
			dac_wr[i] && !output_synchronous[i] && !output_force_clear[i] |=> dac_code[i] == $past(wcode);
		endproperty
		a_async: assert property (p_async) else $error("asynchronous write did not update output");

		property p_load_only_written;
			@(posedge sys_clk) disable iff (rst)
			!dac_wr[i] && (!st_r.load || !dac_pending[i]) |=> dac_live[i] == $past(dac_live[i]);
		endproperty
		a_load_only_written: assert property (p_load_only_written) else $error("output changed without cause");

		property p_load_applies;
			@(posedge sys_clk) disable iff (rst)
			st_r.load && output_synchronous[i] && dac_pending[i] |=> dac_live[i] == $past(dac_data[i]);
		endproperty
		a_load_applies: assert property (p_load_applies) else $error("load did not apply pending data");
	end
endmodule
`default_nettype wire

// *** bench/adc_dac_channel_control_regs_tb_top.sv ***
// Self-checking bench for the converter channel control registers.
// Assumes the design answers every Avalon-MM request within a few cycles of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module adc_dac_channel_control_regs_tb_top;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic [15:0] rexp;
		logic [7:0] pexp;
	} adcr_row_type;
	localparam logic [7:0] RST_ADDR [4] = '{8'hDC, 8'hE0, 8'hE4, 8'hE8};
	localparam logic [15:0] RST_VAL [4] = '{16'h0000, 16'hFF00, 16'h0000, 16'h0000};
	localparam logic [3:0] SCAN_EXP [3] = '{4'h9, 4'h3, 4'h7};
	logic sys_clk;
	logic rst;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] input_select;
	logic [7:0] input_range_double;
	logic [3:0] output_force_clear;
	logic [3:0] output_synchronous;
	logic [3:0][9:0] dac_code;
	logic conv_strobe;
	logic [2:0] conv_channel;
	logic conv_range_double;
	int bad_count;
	int cmp_count;
	int cycle_count;
	logic [3:0] scan_q [$];
	logic [15:0] rd;
	adcr_row_type rows [19];

	adcr_top dut_u (
		.sys_clk(sys_clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.input_select(input_select),
		.input_range_double(input_range_double),
		.output_force_clear(output_force_clear),
		.output_synchronous(output_synchronous),
		.dac_code(dac_code),
		.conv_strobe(conv_strobe),
		.conv_channel(conv_channel),
		.conv_range_double(conv_range_double)
	);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One bus transfer; a clock edge always passes before the request is raised.
	task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= is_wr;
		avs_read <= ~is_wr;
		avs_writedata <= {16'h0000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[15:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk({avs_readdata[31:16], 16'(n)}, 32'h00000002, "bus answer");
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	function automatic logic [7:0] port_of(input logic [7:0] a);
		case (a)
			8'hDC: return input_select;
			8'hE0: return input_range_double;
			8'hE4: return {4'h0, output_force_clear};
			8'hE8: return {4'h0, output_synchronous};
			default: return 8'h00;
		endcase
	endfunction

	// Collects every scan strobe and cuts a hang short.
	always @(posedge sys_clk) begin
		cycle_count <= cycle_count + 1;
		if (conv_strobe === 1'b1) scan_q.push_back({conv_range_double, conv_channel});
		if (cycle_count == 3000) begin
			bad_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		bad_count = 0;
		cmp_count = 0;
		cycle_count = 0;
		rst = 1'b1;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		rows = '{
			'{8'hDC, 16'hEDFF, 16'h6DE0, 8'hFF}, '{8'hDC, 16'h4000, 16'h4000, 8'h01},
			'{8'hDC, 16'h0020, 16'h0020, 8'h80}, '{8'hDC, 16'h2400, 16'h2400, 8'h0A},
			'{8'hDC, 16'h0940, 16'h0940, 8'h54}, '{8'hDC, 16'h00A0, 16'h00A0, 8'hA0},
			'{8'hE0, 16'hFFFF, 16'hFF00, 8'hFF}, '{8'hE0, 16'h8000, 16'h8000, 8'h01},
			'{8'hE0, 16'h00FF, 16'h0000, 8'h00}, '{8'hE0, 16'h0100, 16'h0100, 8'h80},
			'{8'hE4, 16'h0000, 16'h0000, 8'h00}, '{8'hE4, 16'hFFFF, 16'h000F, 8'h0F},
			'{8'hE8, 16'h0000, 16'h0000, 8'h00}, '{8'hE8, 16'hFFF5, 16'h0005, 8'h05},
			'{8'hFC, 16'hFFFF, 16'h0000, 8'h00}, '{8'hA0, 16'h0000, 16'h0000, 8'h00},
			'{8'hBC, 16'hFFFF, 16'h03FF, 8'h00}, '{8'h80, 16'hFFFF, 16'h03FF, 8'h00},
			'{8'hA4, 16'hFFFF, 16'h0010, 8'h00}
		};
		repeat (12) @(posedge sys_clk);
		chk(32'({input_select, input_range_double}), 32'h000000FF, "reset fields");
		chk(32'({output_force_clear, output_synchronous}), 32'h00000000, "reset outputs");
		chk({12'h000, dac_code[1], dac_code[0]}, 32'h00000000, "reset codes low");
		chk({12'h000, dac_code[3], dac_code[2]}, 32'h00000000, "reset codes high");
		rst <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			xfer(1'b0, rows[i].addr, 16'h0000, rd);
			chk(32'(rd), 32'(rows[i].rexp), "readback");
			chk(32'(port_of(rows[i].addr)), 32'(rows[i].pexp), "field port");
		end
		// A second reset in mid-run must restore the select, range, force and update mode registers and output codes 0 and 1.
		@(posedge sys_clk);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		foreach (RST_ADDR[i]) begin
			xfer(1'b0, RST_ADDR[i], 16'h0000, rd);
			chk(32'(rd), 32'(RST_VAL[i]), "reset value");
		end
		chk({12'h000, dac_code[1], dac_code[0]}, 32'h00000000, "codes after reset");
		// Scan of inputs 1, 3 and 7 with only input 1 in the doubled range.
		wr(8'hE0, 16'h4000);
		wr(8'hDC, 16'h2420);
		scan_q.delete();
		wr(8'hA0, 16'h0002);
		idle(14);
		chk(scan_q.size(), 3, "scan count");
		if (scan_q.size() == 3) begin
			foreach (SCAN_EXP[i]) chk(32'(scan_q[i]), 32'(SCAN_EXP[i]), "scan entry");
		end
		// Forcing and releasing an asynchronous output.
		wr(8'h80, 16'h0155);
		idle(3);
		chk(32'(dac_code[0]), 32'h00000155, "async data");
		wr(8'hBC, 16'h02AA);
		wr(8'hE4, 16'h0001);
		idle(3);
		chk(32'(dac_code[0]), 32'h000002AA, "forced code");
		chk(32'(dac_code[1]), 32'h00000000, "unforced neighbour");
		wr(8'hE4, 16'h0000);
		idle(3);
		chk(32'(dac_code[0]), 32'h00000155, "released code");
		// Synchronous outputs move only on a load, and only when written since the last one.
		wr(8'hE8, 16'h0006);
		wr(8'h84, 16'h0123);
		idle(3);
		chk(32'(dac_code[1]), 32'h00000000, "sync holds");
		wr(8'hA0, 16'h0001);
		idle(4);
		chk(32'(dac_code[1]), 32'h00000123, "first load");
		chk(32'(dac_code[2]), 32'h00000000, "unwritten kept");
		// Data written in synchronous mode must not load once its output is back in asynchronous mode.
		wr(8'hE8, 16'h000E);
		wr(8'h8C, 16'h00AB);
		wr(8'hE8, 16'h0006);
		wr(8'h88, 16'h0077);
		wr(8'hA0, 16'h0001);
		idle(4);
		chk(32'(dac_code[2]), 32'h00000077, "second load");
		chk(32'(dac_code[1]), 32'h00000123, "not reloaded");
		chk(32'(dac_code[3]), 32'h00000000, "async not loaded");
		complete_run();
	end
endmodule
`default_nettype wire
